// ===== src/sstl_core.v
// speed command selection and travel limit qualification
`timescale 1ns/1ps
`default_nettype none
`include "sstl_defines.vh"

module sstl_core (
	// clock and reset
	input  wire                          clk,
	input  wire                          rst,
	// power-on pulse: latches pending travel limit, speed source and zero clamp setup
	input  wire                          power_on_load,
	// pending setup values
	input  wire [1:0]                    travel_limit_setup,
	input  wire [1:0]                    speed_source_select,
	input  wire [1:0]                    zero_clamp_function,
	input  wire [`SSTL_STOP_SEQ_W-1:0]   overtravel_stop_sequence,
	input  wire [`SSTL_TIME_W-1:0]       accel_time_setup,
	input  wire [`SSTL_TIME_W-1:0]       decel_time_setup,
	input  wire [`SSTL_TIME_W-1:0]       scurve_time_setup,
	// contact inputs, high = closed to common
	input  wire                          ccw_travel_limit_in,
	input  wire                          cw_travel_limit_in,
	input  wire                          preset_select_bit0,
	input  wire                          preset_select_bit1,
	input  wire                          preset_select_bit2,
	input  wire                          zero_clamp_in,
	// speed sources
	input  wire [`SSTL_SPD_W-1:0]        analog_speed_ref,
	input  wire [`SSTL_SPD_W-1:0]        preset_speed_1,
	input  wire [`SSTL_SPD_W-1:0]        preset_speed_2,
	input  wire [`SSTL_SPD_W-1:0]        preset_speed_3,
	input  wire [`SSTL_SPD_W-1:0]        preset_speed_4,
	input  wire [`SSTL_SPD_W-1:0]        preset_speed_5,
	input  wire [`SSTL_SPD_W-1:0]        preset_speed_6,
	input  wire [`SSTL_SPD_W-1:0]        preset_speed_7,
	input  wire [`SSTL_SPD_W-1:0]        preset_speed_8,
	// speed command result
	output reg  [`SSTL_SPD_W-1:0]        speed_cmd,
	output reg                           speed_cmd_ccw,
	output reg                           speed_cmd_analog,
	output reg  [2:0]                    preset_index,
	output reg                           zero_clamped,
	// profile times for the selected command
	output reg  [`SSTL_TIME_W-1:0]       accel_time,
	output reg  [`SSTL_TIME_W-1:0]       decel_time,
	output reg  [`SSTL_TIME_W-1:0]       scurve_time,
	// travel limit result
	output reg                           ccw_inhibit,
	output reg                           cw_inhibit,
	output reg                           overtravel_stop_req,
	output reg  [`SSTL_STOP_SEQ_W-1:0]   stop_sequence,
	output reg                           overtravel_trip_error
);

// ---------------------------------------------------------------
// power-on latched modes; stop sequence and times follow setup every cycle
// ---------------------------------------------------------------
reg [1:0] tl_mode;
reg [1:0] src_mode;
reg [1:0] zc_mode;

always @(posedge clk or posedge rst)
begin
	if (rst)
	begin
		tl_mode       <= `SSTL_TL_RESET;
		src_mode      <= `SSTL_SRC_RESET;
		zc_mode       <= `SSTL_ZC_RESET;
		stop_sequence <= `SSTL_STOP_SEQ_RST;
		accel_time    <= {`SSTL_TIME_W{1'b0}};
		decel_time    <= {`SSTL_TIME_W{1'b0}};
		scurve_time   <= {`SSTL_TIME_W{1'b0}};
	end
	else
	begin
		if (power_on_load)
		begin
			tl_mode  <= travel_limit_setup;
			src_mode <= speed_source_select;
			zc_mode  <= zero_clamp_function;
		end
		stop_sequence <= overtravel_stop_sequence;
		accel_time    <= accel_time_setup;
		decel_time    <= decel_time_setup;
		scurve_time   <= scurve_time_setup;
	end
end

// ---------------------------------------------------------------
// input synchronisation
// ---------------------------------------------------------------
wire [5:0] sync_in;
wire [5:0] sync_out;

assign sync_in = {zero_clamp_in, preset_select_bit2, preset_select_bit1,
	preset_select_bit0, cw_travel_limit_in, ccw_travel_limit_in};

// reset leaves every contact reading open; the ignore mode chosen at
// reset keeps that from tripping before the first power-on load
sstl_sync #(
	.W(6)
) u_sync (
	.clk  (clk),
	.rst  (rst),
	.din  (sync_in),
	.dout (sync_out)
);

wire ccw_closed;
wire cw_closed;
wire [2:0] sel;
wire zc_closed;

assign ccw_closed = sync_out[0];
assign cw_closed  = sync_out[1];
assign sel        = sync_out[4:2];
assign zc_closed  = sync_out[5];

// ---------------------------------------------------------------
// travel limit decode
// ---------------------------------------------------------------
reg next_ccw_inhibit;
reg next_cw_inhibit;
reg next_trip;

always @*
begin
	next_ccw_inhibit = 1'b0;
	next_cw_inhibit  = 1'b0;
	next_trip        = overtravel_trip_error;
	case (tl_mode)
		`SSTL_TL_STOP:
		begin
			next_ccw_inhibit = ~ccw_closed;
			next_cw_inhibit  = ~cw_closed;
			if (~ccw_closed & ~cw_closed)
				next_trip = 1'b1;
		end
		`SSTL_TL_IGNORE:
		begin
			next_ccw_inhibit = 1'b0;
			next_cw_inhibit  = 1'b0;
		end
		`SSTL_TL_TRIP_ANY:
		begin
			if (~ccw_closed | ~cw_closed)
				next_trip = 1'b1;
		end
		default:
		begin
			next_ccw_inhibit = 1'b0;
			next_cw_inhibit  = 1'b0;
		end
	endcase
end

// ---------------------------------------------------------------
// travel limit registers
// ---------------------------------------------------------------
// trip error is sticky until reset or the next power-on load, which
// stands for a restart of control power and so clears it outright
always @(posedge clk or posedge rst)
begin
	if (rst)
	begin
		ccw_inhibit           <= 1'b0;
		cw_inhibit            <= 1'b0;
		overtravel_stop_req   <= 1'b0;
		overtravel_trip_error <= 1'b0;
	end
	else
	begin
		ccw_inhibit         <= next_ccw_inhibit;
		cw_inhibit          <= next_cw_inhibit;
		overtravel_stop_req <= next_ccw_inhibit | next_cw_inhibit;
		if (power_on_load)
			overtravel_trip_error <= 1'b0;
		else
			overtravel_trip_error <= next_trip;
	end
end

// ---------------------------------------------------------------
// speed source selection
// ---------------------------------------------------------------
reg [`SSTL_SPD_W-1:0] src_speed;
reg [`SSTL_SPD_W-1:0] next_speed;
reg                   next_analog;
reg [2:0]             next_index;
reg                   next_ccw;
reg                   next_clamp;

always @*
begin
	next_analog = 1'b0;
	next_index  = 3'h0;
	case (src_mode)
		`SSTL_SRC_ANALOG:
			next_analog = 1'b1;
		`SSTL_SRC_PRESET4:
			next_index = {1'b0, sel[1:0]};
		`SSTL_SRC_PRESET3:
		begin
			next_index = {1'b0, sel[1:0]};
			if (sel[1:0] == 2'h3)
				next_analog = 1'b1;
		end
		`SSTL_SRC_PRESET8:
			next_index = sel;
		default:
			next_analog = 1'b1;
	endcase
end

// ---------------------------------------------------------------
// preset multiplexer
// ---------------------------------------------------------------
// index 4 to 7 reaches the second bank; only source 3 sets bit 2
always @*
begin
	if (next_analog)
		src_speed = analog_speed_ref;
	else
	begin
		case (next_index)
			3'h0: src_speed = preset_speed_1;
			3'h1: src_speed = preset_speed_2;
			3'h2: src_speed = preset_speed_3;
			3'h3: src_speed = preset_speed_4;
			3'h4: src_speed = preset_speed_5;
			3'h5: src_speed = preset_speed_6;
			3'h6: src_speed = preset_speed_7;
			default: src_speed = preset_speed_8;
		endcase
	end
end

// ---------------------------------------------------------------
// zero clamp and direction sign
// ---------------------------------------------------------------
// the clamp overrides whichever source was chosen, analog included
always @*
begin
	next_ccw   = 1'b0;
	next_clamp = 1'b0;
	case (zc_mode)
		`SSTL_ZC_OFF:
			next_clamp = 1'b0;
		`SSTL_ZC_CLAMP:
			next_clamp = ~zc_closed;
		`SSTL_ZC_SIGN:
			next_ccw = ~zc_closed;
		default:
			next_clamp = 1'b0;
	endcase
	if (next_clamp)
		next_speed = {`SSTL_SPD_W{1'b0}};
	else
		next_speed = src_speed;
end

// ---------------------------------------------------------------
// speed command registers
// ---------------------------------------------------------------
always @(posedge clk or posedge rst)
begin
	if (rst)
	begin
		speed_cmd        <= {`SSTL_SPD_W{1'b0}};
		speed_cmd_ccw    <= 1'b0;
		speed_cmd_analog <= 1'b1;
		preset_index     <= 3'h0;
		zero_clamped     <= 1'b0;
	end
	else
	begin
		speed_cmd        <= next_speed;
		speed_cmd_ccw    <= next_ccw;
		speed_cmd_analog <= next_analog;
		preset_index     <= next_index;
		zero_clamped     <= next_clamp;
	end
end

endmodule

`default_nettype wire

// ===== src/sstl_defines.vh
// constants for the speed source and travel limit block
`ifndef SSTL_DEFINES_VH
`define SSTL_DEFINES_VH

// travel limit setup values
`define SSTL_TL_STOP      2'h0
`define SSTL_TL_IGNORE    2'h1
`define SSTL_TL_TRIP_ANY  2'h2
`define SSTL_TL_RESET     2'h1

// speed source setup values
`define SSTL_SRC_ANALOG   2'h0
`define SSTL_SRC_PRESET4  2'h1
`define SSTL_SRC_PRESET3  2'h2
`define SSTL_SRC_PRESET8  2'h3
`define SSTL_SRC_RESET    2'h0

// zero clamp function values
`define SSTL_ZC_OFF       2'h0
`define SSTL_ZC_CLAMP     2'h1
`define SSTL_ZC_SIGN      2'h2
`define SSTL_ZC_RESET     2'h0

// widths
`define SSTL_SPD_W        16
`define SSTL_TIME_W       16

// stop sequence encoding
`define SSTL_STOP_SEQ_W   3
`define SSTL_STOP_SEQ_RST 3'h0

`endif

// ===== src/sstl_sync.v
// two flop synchroniser for a group of contact inputs
`timescale 1ns/1ps
`default_nettype none

module sstl_sync #(
	parameter W = 6
) (
	// clock and reset
	input  wire         clk,
	input  wire         rst,
	// data
	input  wire [W-1:0] din,
	output reg  [W-1:0] dout
);

reg [W-1:0] stage1;

genvar i;
generate
	for (i = 0; i < W; i = i + 1)
	begin : g_bit
		always @(posedge clk or posedge rst)
		begin
			if (rst)
			begin
				stage1[i] <= 1'b0;
				dout[i]   <= 1'b0;
			end
			else
			begin
				stage1[i] <= din[i];
				dout[i]   <= stage1[i];
			end
		end
	end
endgenerate

endmodule

`default_nettype wire

// ===== verification/sstl_chk.sv
// assertion checker for the speed source and travel limit block
`timescale 1ns/1ps
`default_nettype none
module sstl_chk (
	// clock and reset
	input wire logic        clk,
	input wire logic        rst,
	// setup and contacts
	input wire logic        power_on_load,
	input wire logic [1:0]  travel_limit_setup,
	input wire logic [1:0]  speed_source_select,
	input wire logic [1:0]  zero_clamp_function,
	input wire logic        ccw_travel_limit_in,
	input wire logic        cw_travel_limit_in,
	input wire logic        preset_select_bit0,
	input wire logic        preset_select_bit1,
	input wire logic        preset_select_bit2,
	input wire logic        zero_clamp_in,
	// results
	input wire logic [15:0] speed_cmd,
	input wire logic        speed_cmd_analog,
	input wire logic [2:0]  preset_index,
	input wire logic        zero_clamped,
	input wire logic        ccw_inhibit,
	input wire logic        cw_inhibit,
	input wire logic        overtravel_trip_error
);
	// ----
	// modes and contacts as the output stage sees them
	// ----
	reg  [1:0] up;
	reg        lp;
	reg  [5:0] md;
	reg  [5:0] m;
	reg  [5:0] d1;
	reg  [5:0] d2;
	reg  [5:0] d;
	wire       ok = &up && !lp;
	always @(posedge clk or posedge rst)
		if (rst)
		begin
			up <= 2'h0;
			lp <= 1'h0;
			md <= 6'h10;
			m <= 6'h10;
			d1 <= 6'h0;
			d2 <= 6'h0;
			d <= 6'h0;
		end
		else
		begin
			up <= up + {1'h0, ~&up};
			lp <= power_on_load;
			if (power_on_load)
				md <= {travel_limit_setup, speed_source_select,
					zero_clamp_function};
			m <= md;
			d1 <= {ccw_travel_limit_in, cw_travel_limit_in, preset_select_bit2,
				preset_select_bit1, preset_select_bit0, zero_clamp_in};
			d2 <= d1;
			d <= d2;
		end
	// ----
	// properties
	// ----
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	property p_ign;
		ok && m[5:4] == 2'h1 |-> !ccw_inhibit && !cw_inhibit;
	endproperty
	a_ign: assert property (p_ign) else $error("limit not ignored");
	property p_any;
		ok && m[5:4] == 2'h2 && d[5:4] != 2'h3 |-> overtravel_trip_error;
	endproperty
	a_any: assert property (p_any) else $error("no trip on open");
	property p_both;
		ok && m[5:4] == 2'h0 && d[5:4] == 2'h0 |-> overtravel_trip_error;
	endproperty
	a_both: assert property (p_both) else $error("no trip on both");
	property p_dir;
		ok && m[5:4] == 2'h0 |-> ccw_inhibit == !d[5] && cw_inhibit == !d[4];
	endproperty
	a_dir: assert property (p_dir) else $error("bad inhibit");
	property p_p3;
		ok && m[3:2] == 2'h2 |-> speed_cmd_analog == (d[2:1] == 2'h3);
	endproperty
	a_p3: assert property (p_p3) else $error("bad source 2");
	property p_p4;
		ok && m[3:2] == 2'h1 |-> preset_index == {1'h0, d[2:1]};
	endproperty
	a_p4: assert property (p_p4) else $error("bad source 1");
	property p_p8;
		ok && m[3:2] == 2'h3 |-> preset_index == d[3:1] && !speed_cmd_analog;
	endproperty
	a_p8: assert property (p_p8) else $error("bad source 3");
	property p_clp;
		ok && m[1:0] == 2'h1 && !d[0] |-> speed_cmd == 16'h0 && zero_clamped;
	endproperty
	a_clp: assert property (p_clp) else $error("not clamped");
	c_trip: cover property (overtravel_trip_error);
	c_clamp: cover property (zero_clamped);
	c_top: cover property (ok && m[3:2] == 2'h3 && preset_index == 3'h7);
endmodule
bind sstl_core sstl_chk u_sstl_chk (
	.clk(clk), .rst(rst), .power_on_load(power_on_load),
	.travel_limit_setup(travel_limit_setup),
	.speed_source_select(speed_source_select),
	.zero_clamp_function(zero_clamp_function),
	.ccw_travel_limit_in(ccw_travel_limit_in),
	.cw_travel_limit_in(cw_travel_limit_in),
	.preset_select_bit0(preset_select_bit0),
	.preset_select_bit1(preset_select_bit1),
	.preset_select_bit2(preset_select_bit2),
	.zero_clamp_in(zero_clamp_in), .speed_cmd(speed_cmd),
	.speed_cmd_analog(speed_cmd_analog), .preset_index(preset_index),
	.zero_clamped(zero_clamped), .ccw_inhibit(ccw_inhibit),
	.cw_inhibit(cw_inhibit),
	.overtravel_trip_error(overtravel_trip_error)
);
`default_nettype wire

// ===== verification/sstl_field.sv
// contact model for limit switches and host contact outputs
`timescale 1ns/1ps
`default_nettype none
module sstl_field (
	// clock
	input  wire logic       clk,
	// requested and driven contacts, high = closed
	input  wire logic [5:0] req,
	output var  logic [5:0] pin
);
	initial
		pin = 6'h3f;
	// all contacts move together just after an edge
	always @(posedge clk)
		pin <= req;
endmodule
`default_nettype wire

// ===== verification/test_sstl_core.sv
// self-checking bench for the speed source and travel limit block
`timescale 1ns/1ps
`default_nettype none
module test_sstl_core;
	logic        clk = 1'h0;
	logic        rst = 1'h1;
	logic        power_on_load = 1'h0;
	logic [1:0]  travel_limit_setup = 2'h0;
	logic [1:0]  speed_source_select = 2'h0;
	logic [1:0]  zero_clamp_function = 2'h0;
	logic [2:0]  overtravel_stop_sequence = 3'h0;
	logic [15:0] accel_time_setup = 16'h0;
	logic [15:0] decel_time_setup = 16'h0;
	logic [15:0] scurve_time_setup = 16'h0;
	logic [15:0] analog_speed_ref = 16'h0;
	logic [15:0] pv [8] = '{default: 16'h0};
	logic [5:0]  req = 6'h3f;
	logic        trip;
	wire  [15:0] speed_cmd, accel_time, decel_time, scurve_time;
	wire  [2:0]  preset_index, stop_sequence;
	wire         speed_cmd_ccw, speed_cmd_analog, zero_clamped, ccw_inhibit;
	wire         cw_inhibit, overtravel_stop_req, overtravel_trip_error;
	wire         ccw_travel_limit_in, cw_travel_limit_in, zero_clamp_in;
	wire         preset_select_bit0, preset_select_bit1, preset_select_bit2;
	integer      fail_count = 0, n_checks = 0, tl, ss, zc;
	sstl_core u_sstl_core (
		.clk(clk), .rst(rst), .power_on_load(power_on_load),
		.travel_limit_setup(travel_limit_setup),
		.speed_source_select(speed_source_select),
		.zero_clamp_function(zero_clamp_function),
		.overtravel_stop_sequence(overtravel_stop_sequence),
		.accel_time_setup(accel_time_setup),
		.decel_time_setup(decel_time_setup),
		.scurve_time_setup(scurve_time_setup),
		.ccw_travel_limit_in(ccw_travel_limit_in),
		.cw_travel_limit_in(cw_travel_limit_in),
		.preset_select_bit0(preset_select_bit0),
		.preset_select_bit1(preset_select_bit1),
		.preset_select_bit2(preset_select_bit2),
		.zero_clamp_in(zero_clamp_in),
		.analog_speed_ref(analog_speed_ref),
		.preset_speed_1(pv[0]), .preset_speed_2(pv[1]),
		.preset_speed_3(pv[2]), .preset_speed_4(pv[3]),
		.preset_speed_5(pv[4]), .preset_speed_6(pv[5]),
		.preset_speed_7(pv[6]), .preset_speed_8(pv[7]),
		.speed_cmd(speed_cmd), .speed_cmd_ccw(speed_cmd_ccw),
		.speed_cmd_analog(speed_cmd_analog),
		.preset_index(preset_index), .zero_clamped(zero_clamped),
		.accel_time(accel_time), .decel_time(decel_time),
		.scurve_time(scurve_time), .ccw_inhibit(ccw_inhibit),
		.cw_inhibit(cw_inhibit),
		.overtravel_stop_req(overtravel_stop_req),
		.stop_sequence(stop_sequence),
		.overtravel_trip_error(overtravel_trip_error)
	);
	sstl_field u_sstl_field (
		.clk(clk),
		.req(req),
		.pin({ccw_travel_limit_in, cw_travel_limit_in, preset_select_bit2,
			preset_select_bit1, preset_select_bit0, zero_clamp_in})
	);
	always #5 clk = ~clk;
	function automatic logic hit(input logic [5:0] c);
		hit = (tl == 0 && c[5:4] == 2'h0) || (tl == 2 && c[5:4] != 2'h3);
	endfunction
	task automatic ck(input logic [15:0] g, input logic [15:0] e);
		n_checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("Error at %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic run_one;
		logic [2:0]  idx;
		logic        ana;
		logic [15:0] e;
		trip = trip | hit(req);
		@(posedge clk);
		req <= 6'($urandom);
		analog_speed_ref <= 16'($urandom);
		for (int i = 0; i < 8; i++)
			pv[i] <= 16'($urandom);
		// mode setup changes without a load must not act; stop sequence and times follow at once
		{travel_limit_setup, speed_source_select} <= 4'($urandom);
		zero_clamp_function <= 2'($urandom);
		overtravel_stop_sequence <= 3'($urandom);
		accel_time_setup <= 16'($urandom);
		decel_time_setup <= 16'($urandom);
		scurve_time_setup <= 16'($urandom);
		repeat (6) @(posedge clk);
		trip = trip | hit(req);
		idx = (ss == 3) ? req[3:1] : {1'h0, req[2:1]};
		ana = ss == 0 || (ss == 2 && idx == 3'h3);
		e = (zc == 1 && !req[0]) ? 16'h0 : ana ? analog_speed_ref : pv[idx];
		ck(speed_cmd, e);
		ck({15'h0, speed_cmd_analog}, {15'h0, ana});
		if (!ana)
			ck({13'h0, preset_index}, {13'h0, idx});
		ck({10'h0, speed_cmd_ccw, zero_clamped, ccw_inhibit, cw_inhibit,
			overtravel_stop_req, overtravel_trip_error}, {10'h0,
			zc == 2 && !req[0], zc == 1 && !req[0], tl == 0 && !req[5],
			tl == 0 && !req[4], tl == 0 && req[5:4] != 2'h3,
			trip});
		ck({13'h0, stop_sequence}, {13'h0, overtravel_stop_sequence});
		ck(accel_time, accel_time_setup);
		ck(decel_time, decel_time_setup);
		ck(scurve_time, scurve_time_setup);
	endtask
	task complete_run;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		#200000;
		fail_count++;
		complete_run;
	end
	initial
	begin
		void'($urandom(37802));
		repeat (10) @(posedge clk);
		rst <= 1'h0;
		for (tl = 0; tl < 3; tl++)
			for (ss = 0; ss < 4; ss++)
				for (zc = 0; zc < 3; zc++)
				begin
					@(posedge clk);
					travel_limit_setup <= 2'(tl);
					speed_source_select <= 2'(ss);
					zero_clamp_function <= 2'(zc);
					power_on_load <= 1'h1;
					@(posedge clk);
					power_on_load <= 1'h0;
					trip = 1'h0;
					repeat (12) run_one;
					$display("mode %0d %0d %0d done", tl, ss, zc);
				end
		complete_run;
	end
endmodule
`default_nettype wire
